// ===== verilog/sws_pkg.sv
// Function
// - fixed level: bias to level, hold
// - fixed level takes 1..1000 measurements
// - full delay precedes every fixed and stair measurement
// - fixed level returns to bias after last
// - linear stair: start, equal steps to stop
// - stairs: hold delay, then one measurement
// - stairs: back to bias after stop measurement
// - points per decade only 5/10/25/50
// - log steps evenly spaced per decade
// - single pulse: 1..500 pulses at level
// - pulse on time, bias for off time
// - two measurements per pulse, on and off
// - linear pulse levels step to stop
// - every result written to sweep buffer
// - idle operating output holds bias
// - delay 0..65 s in milliseconds
// - on/off time 1 ms..65 s
// - clamp at 1000 points, flag filled
`default_nettype none
package sws_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  // cycles per millisecond, exact at 50 MHz
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // programmable time limits in milliseconds
  localparam logic [15:0] DELAY_MAX_MS = 16'hFDE8;  // 65000
  localparam logic [15:0] PULSE_MIN_MS = 16'h0001;
  localparam logic [15:0] PULSE_MAX_MS = 16'hFDE8;  // 65000
  // default widths and capacities
  localparam int LVL_W_D      = 16;
  localparam int MEAS_W_D     = 16;
  localparam int MAX_PTS_D    = 1000;
  localparam int MAX_PULSES_D = 500;
  // log ratios 10^(1/n) in unsigned q2.16
  localparam int RATIO_FRAC = 16;
  localparam logic [17:0] RATIO_PPD5  = 18'h195BE;
  localparam logic [17:0] RATIO_PPD10 = 18'h14249;
  localparam logic [17:0] RATIO_PPD25 = 18'h118B2;
  localparam logic [17:0] RATIO_PPD50 = 18'h10C10;
  // points per decade selector
  localparam logic [1:0] PPD_5  = 2'h0;
  localparam logic [1:0] PPD_10 = 2'h1;
  localparam logic [1:0] PPD_25 = 2'h2;
  localparam logic [1:0] PPD_50 = 2'h3;
  // sweep shapes
  typedef enum logic [2:0] {
    W_FIXED = 3'h0,
    W_LIN   = 3'h1,
    W_LOG   = 3'h2,
    W_PULSE = 3'h3,
    W_LPUL  = 3'h4,
    W_GPUL  = 3'h5
  } sws_wave_t;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_DLY  = 5'h02,
    S_ON   = 5'h04,
    S_OFF  = 5'h08,
    S_WAIT = 5'h10
  } sws_state_t;
endpackage : sws_pkg
`default_nettype wire

// ===== verilog/sws_logstep.sv
`default_nettype none
// next level of a log staircase, one ratio multiply
module sws_logstep import sws_pkg::*; #(
  parameter int LVL_W = LVL_W_D
) (
  input  wire logic [LVL_W-1:0] lvl,
  input  wire logic [LVL_W-1:0] stop_lvl,
  input  wire logic [1:0]       ppd_sel,
  output logic      [LVL_W-1:0] nxt
);
  logic [17:0]        ratio;   // per-decade ratio
  logic [LVL_W-1:0]   mag;     // magnitude of current level
  logic [LVL_W-1:0]   smag;    // magnitude of stop level
  logic [LVL_W+17:0]  prod;    // scaled product
  logic [LVL_W+1:0]   nmag;    // next magnitude
  logic [LVL_W-1:0]   signed_n;

  // ratio lookup and step; sign of the start is kept
  always_comb begin
    unique case (ppd_sel)
      PPD_5:   ratio = RATIO_PPD5;
      PPD_10:  ratio = RATIO_PPD10;
      PPD_25:  ratio = RATIO_PPD25;
      PPD_50:  ratio = RATIO_PPD50;
    endcase
    mag  = lvl[LVL_W-1] ? LVL_W'(-lvl) : lvl;
    smag = stop_lvl[LVL_W-1] ? LVL_W'(-stop_lvl) : stop_lvl;
    // constant ratio gives equal log spacing
    prod = (LVL_W+18)'(mag) * (LVL_W+18)'(ratio);
    nmag = prod[RATIO_FRAC +: LVL_W+2];
    // tiny levels would stall; force one code of progress
    if (nmag[LVL_W-1:0] == mag && nmag[LVL_W+1:LVL_W] == 2'h0) begin
      nmag = (LVL_W+2)'(mag) + (LVL_W+2)'(1);
    end
    signed_n = lvl[LVL_W-1] ? LVL_W'(-nmag[LVL_W-1:0]) : nmag[LVL_W-1:0];
    // clamp onto stop once it would be passed
    if (nmag >= (LVL_W+2)'(smag)) begin
      nxt = stop_lvl;
    end else begin
      nxt = signed_n;
    end
  end
endmodule // sws_logstep
`default_nettype wire

// ===== verilog/sws_top.sv
`default_nettype none
// sweep sequencer: source steps, timing, measure strobes, result buffer
module sws_top import sws_pkg::*; #(
  parameter int LVL_W      = LVL_W_D,
  parameter int MEAS_W     = MEAS_W_D,
  parameter int MAX_PTS    = MAX_PTS_D,
  parameter int MAX_PULSES = MAX_PULSES_D,
  parameter int TICK_CYC   = MS_CYCLES
) (
  input  wire logic              CLK,
  input  wire logic              NRST,
  input  wire logic              CE,
  input  wire logic              OPERATE,
  input  wire logic              TRIG,
  input  wire logic              TRIG_PACE,
  input  wire logic [2:0]        WAVE_SEL,
  input  wire logic [LVL_W-1:0]  BIAS,
  input  wire logic [LVL_W-1:0]  LEVEL,
  input  wire logic [LVL_W-1:0]  START_LVL,
  input  wire logic [LVL_W-1:0]  STOP_LVL,
  input  wire logic [LVL_W-1:0]  STEP,
  input  wire logic [1:0]        PPD_SEL,
  input  wire logic [15:0]       POINTS,
  input  wire logic [15:0]       DELAY_MS,
  input  wire logic [15:0]       TON_MS,
  input  wire logic [15:0]       TOFF_MS,
  input  wire logic [MEAS_W-1:0] MEAS_DATA,
  input  wire logic [9:0]        RD_ADDR,
  output logic      [LVL_W-1:0]  SRC_LEVEL,
  output logic                   MEAS_STB,
  output logic                   BUSY,
  output logic                   DONE,
  output logic                   BUF_FILLED,
  output logic      [9:0]        BUF_COUNT,
  output logic      [MEAS_W-1:0] RD_DATA
);
  localparam int TW = $clog2(TICK_CYC + 1);

  // refuse sizes the counters and buffer cannot hold
  if (MAX_PTS > 1023 || MAX_PTS != 2 * MAX_PULSES || TICK_CYC < 1 || LVL_W < 4) begin : g_chk
    $error("sws_top: unsupported parameter set");
  end

  sws_state_t       st_r, st_nxt;          // sequencer state
  sws_wave_t        wave_r, wave_nxt;      // latched shape
  logic [LVL_W-1:0] src_r, src_nxt;        // driven source level
  logic [LVL_W-1:0] lvl_r, lvl_nxt;        // current step level
  logic [LVL_W-1:0] bias_r, bias_nxt;      // bias for this sweep
  logic [LVL_W-1:0] stop_r, stop_nxt;
  logic [LVL_W-1:0] step_r, step_nxt;
  logic [1:0]       ppd_r, ppd_nxt;
  logic [9:0]       pts_r, pts_nxt;        // clamped point or pulse count
  logic [15:0]      dly_r, dly_nxt;
  logic [15:0]      ton_r, ton_nxt;
  logic [15:0]      toff_r, toff_nxt;
  logic [9:0]       cnt_r, cnt_nxt;        // results stored
  logic [9:0]       pcnt_r, pcnt_nxt;      // pulses finished
  logic             filled_r, filled_nxt;
  logic             done_r, done_nxt;
  logic             pace_r, pace_nxt;      // trigger pacing latched
  logic [15:0]      ms_r, ms_nxt;          // milliseconds left
  logic [TW-1:0]    tick_r, tick_nxt;      // cycles in current ms
  logic             ld;                    // timer load request
  logic [15:0]      ld_val;
  logic             tdone;                 // interval elapsed
  logic             meas;                  // strobe this cycle
  logic             last;                  // sweep ends on this strobe
  logic             full;                  // this strobe fills buffer
  logic             pulse_w;               // shape is a pulse shape
  logic [LVL_W-1:0] log_nxt;
  logic [LVL_W:0]   lin_sum;
  logic             lin_past;
  logic [LVL_W-1:0] adv_lvl;               // next staircase level
  logic [MEAS_W-1:0] mem [0:MAX_PTS-1];    // sweep buffer
  logic [MEAS_W-1:0] rd_r;

  sws_logstep #(.LVL_W(LVL_W)) sws_logstep_inst (
    .lvl      (lvl_r),
    .stop_lvl (stop_r),
    .ppd_sel  (ppd_r),
    .nxt      (log_nxt)
  );

  assign tdone   = (ms_r == 16'h0000);
  assign pulse_w = (wave_r == W_PULSE) || (wave_r == W_LPUL) || (wave_r == W_GPUL);
  assign full    = (cnt_r == 10'(MAX_PTS - 1));

  // sequencer next state
  always_comb begin
    st_nxt = st_r;  wave_nxt = wave_r;  src_nxt = src_r;  lvl_nxt = lvl_r;
    bias_nxt = bias_r;  stop_nxt = stop_r;  step_nxt = step_r;  ppd_nxt = ppd_r;
    pts_nxt = pts_r;  dly_nxt = dly_r;  ton_nxt = ton_r;  toff_nxt = toff_r;
    cnt_nxt = cnt_r;  pcnt_nxt = pcnt_r;  filled_nxt = filled_r;
    done_nxt = 1'b0;  pace_nxt = pace_r;
    ld = 1'b0;  ld_val = 16'h0000;  meas = 1'b0;  last = 1'b0;
    lin_sum  = {lvl_r[LVL_W-1], lvl_r} + {step_r[LVL_W-1], step_r};
    lin_past = step_r[LVL_W-1] ? ($signed(lin_sum) <= $signed({stop_r[LVL_W-1], stop_r}))
                               : ($signed(lin_sum) >= $signed({stop_r[LVL_W-1], stop_r}));
    if (wave_r == W_LOG || wave_r == W_GPUL) begin
      adv_lvl = log_nxt;
    end else if (wave_r == W_LIN || wave_r == W_LPUL) begin
      adv_lvl = lin_past ? stop_r : lin_sum[LVL_W-1:0];
    end else begin
      adv_lvl = lvl_r;  // fixed and single pulse never move
    end
    unique case (st_r)
      S_IDLE: begin
        src_nxt  = BIAS;
        bias_nxt = BIAS;
        if (TRIG && OPERATE && WAVE_SEL <= 3'(W_GPUL)) begin
          wave_nxt = sws_wave_t'(WAVE_SEL);
          stop_nxt = STOP_LVL;  step_nxt = STEP;  ppd_nxt = PPD_SEL;
          pace_nxt = TRIG_PACE;
          cnt_nxt = 10'h000;  pcnt_nxt = 10'h000;  filled_nxt = 1'b0;
          dly_nxt  = (DELAY_MS > DELAY_MAX_MS) ? DELAY_MAX_MS : DELAY_MS;
          // on and off kept within 1 ms..65 s
          ton_nxt  = (TON_MS < PULSE_MIN_MS) ? PULSE_MIN_MS :
                     (TON_MS > PULSE_MAX_MS) ? PULSE_MAX_MS : TON_MS;
          toff_nxt = (TOFF_MS < PULSE_MIN_MS) ? PULSE_MIN_MS :
                     (TOFF_MS > PULSE_MAX_MS) ? PULSE_MAX_MS : TOFF_MS;
          if (WAVE_SEL == 3'(W_PULSE)) begin
            pts_nxt = (POINTS > 16'(MAX_PULSES)) ? 10'(MAX_PULSES) : 10'(POINTS);
          end else begin
            pts_nxt = (POINTS > 16'(MAX_PTS)) ? 10'(MAX_PTS) : 10'(POINTS);
          end
          if (POINTS == 16'h0000) begin
            pts_nxt = 10'h001;
          end
          if (WAVE_SEL == 3'(W_FIXED) && POINTS > 16'(MAX_PTS)) begin
            filled_nxt = 1'b1;
          end
          if (WAVE_SEL == 3'(W_PULSE) && POINTS > 16'(MAX_PULSES)) begin
            filled_nxt = 1'b1;
          end
          // first level is level or start
          lvl_nxt = (WAVE_SEL == 3'(W_FIXED) || WAVE_SEL == 3'(W_PULSE)) ? LEVEL : START_LVL;
          src_nxt = lvl_nxt;
          ld = 1'b1;
          if (WAVE_SEL >= 3'(W_PULSE)) begin
            st_nxt = S_ON;
            ld_val = ton_nxt;
          end else begin
            st_nxt = S_DLY;
            ld_val = dly_nxt;
          end
        end
      end
      S_DLY: begin
        if (tdone) begin
          meas = 1'b1;
          cnt_nxt = cnt_r + 10'h001;
          // one measurement per step; exact count
          last = (wave_r == W_FIXED) ? (cnt_nxt >= pts_r) : (lvl_r == stop_r);
          if (full && !last) begin
            filled_nxt = 1'b1;  // clamp at buffer size
          end
          if (last || full) begin
            // back to bias; after stop level
            st_nxt = S_IDLE;  src_nxt = bias_r;  done_nxt = 1'b1;
          end else begin
            lvl_nxt = adv_lvl;
            if (pace_r) begin
              st_nxt = S_WAIT;
            end else begin
              st_nxt = S_DLY;  src_nxt = adv_lvl;  ld = 1'b1;  ld_val = dly_r;
            end
          end
        end
      end
      S_ON: begin
        // hold level for on time; on-level result
        if (tdone) begin
          meas = 1'b1;
          cnt_nxt = cnt_r + 10'h001;
          src_nxt = bias_r;
          if (full) begin
            st_nxt = S_IDLE;  filled_nxt = 1'b1;  done_nxt = 1'b1;
          end else begin
            st_nxt = S_OFF;  ld = 1'b1;  ld_val = toff_r;
          end
        end
      end
      S_OFF: begin
        // bias for off time; off-level result
        if (tdone) begin
          meas = 1'b1;
          cnt_nxt = cnt_r + 10'h001;
          pcnt_nxt = pcnt_r + 10'h001;
          // stepped pulses end at stop; pulse count
          last = (wave_r == W_PULSE) ? (pcnt_nxt >= pts_r) : (lvl_r == stop_r);
          if (full && !last) begin
            filled_nxt = 1'b1;
          end
          if (last || full) begin
            st_nxt = S_IDLE;  done_nxt = 1'b1;
          end else begin
            lvl_nxt = adv_lvl;
            if (pace_r) begin
              st_nxt = S_WAIT;
            end else begin
              st_nxt = S_ON;  src_nxt = adv_lvl;  ld = 1'b1;  ld_val = ton_r;
            end
          end
        end
      end
      S_WAIT: begin
        // paced sweeps step only on trigger
        if (TRIG) begin
          src_nxt = lvl_r;
          ld = 1'b1;
          st_nxt = pulse_w ? S_ON : S_DLY;
          ld_val = pulse_w ? ton_r : dly_r;
        end
      end
    endcase
    // leaving operate aborts the sweep at bias
    if (!OPERATE && st_r != S_IDLE) begin
      st_nxt = S_IDLE;  src_nxt = bias_r;  done_nxt = 1'b1;  ld = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_r <= S_IDLE;  wave_r <= W_FIXED;  src_r <= '0;  lvl_r <= '0;
      bias_r <= '0;  stop_r <= '0;  step_r <= '0;  ppd_r <= PPD_5;
      pts_r <= 10'h001;  dly_r <= 16'h0000;  ton_r <= PULSE_MIN_MS;  toff_r <= PULSE_MIN_MS;
      cnt_r <= 10'h000;  pcnt_r <= 10'h000;  filled_r <= 1'b0;  done_r <= 1'b0;
      pace_r <= 1'b0;
    end else if (CE) begin
      st_r <= st_nxt;  wave_r <= wave_nxt;  src_r <= src_nxt;  lvl_r <= lvl_nxt;
      bias_r <= bias_nxt;  stop_r <= stop_nxt;  step_r <= step_nxt;  ppd_r <= ppd_nxt;
      pts_r <= pts_nxt;  dly_r <= dly_nxt;  ton_r <= ton_nxt;  toff_r <= toff_nxt;
      cnt_r <= cnt_nxt;  pcnt_r <= pcnt_nxt;  filled_r <= filled_nxt;  done_r <= done_nxt;
      pace_r <= pace_nxt;
    end
  end

  // millisecond timer; a zero load ends at once for zero delay
  always_comb begin
    ms_nxt = ms_r;
    tick_nxt = tick_r;
    if (ld) begin
      ms_nxt = ld_val;
      tick_nxt = '0;
    end else if (!tdone) begin
      if (tick_r == TW'(TICK_CYC - 1)) begin
        tick_nxt = '0;
        ms_nxt = ms_r - 16'h0001;
      end else begin
        tick_nxt = tick_r + TW'(1);
      end
    end
  end

  // timer registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ms_r <= 16'h0000;
      tick_r <= '0;
    end else if (CE) begin
      ms_r <= ms_nxt;
      tick_r <= tick_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (CE && meas) begin
      mem[cnt_r] <= MEAS_DATA;
    end
  end

  // registered read port; holes above capacity read zero
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rd_r <= '0;
    end else if (CE) begin
      rd_r <= (RD_ADDR < 10'(MAX_PTS)) ? mem[RD_ADDR] : '0;
    end
  end

  assign SRC_LEVEL  = src_r;
  assign MEAS_STB   = meas && CE;
  assign BUSY       = (st_r != S_IDLE);
  assign DONE       = done_r;
  assign BUF_FILLED = filled_r;
  assign BUF_COUNT  = cnt_r;
  assign RD_DATA    = rd_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  chk_idle_bias: assert property (st_r == S_IDLE && CE && !TRIG |=> src_r == $past(BIAS))
    else $error("idle output not at bias");
  chk_no_start: assert property (st_r == S_IDLE && !TRIG |=> st_r == S_IDLE)
    else $error("sweep started without trigger");
  chk_strobe_delay: assert property (meas |-> ms_r == 16'h0000 && st_r != S_IDLE)
    else $error("strobe before interval ended");
  chk_timer_load: assert property (ld && CE && ld_val != 16'h0000 |=> !meas
                                   && ms_r == $past(ld_val))
    else $error("interval not loaded before strobe");
  chk_fixed_hold: assert property (st_r == S_DLY && wave_r == W_FIXED |-> src_r == lvl_r)
    else $error("fixed level not held");
  chk_fixed_count: assert property (meas && wave_r == W_FIXED |-> cnt_r < pts_r)
    else $error("fixed sweep took too many points");
  chk_on_level: assert property (st_r == S_ON |-> src_r == lvl_r)
    else $error("pulse not at level during on time");
  chk_off_bias: assert property (st_r == S_OFF |-> src_r == bias_r)
    else $error("pulse not at bias during off time");
  chk_pulse_pair: assert property (st_r == S_ON && MEAS_STB && !full && OPERATE
                                   |=> st_r == S_OFF)
    else $error("on result not followed by off phase");
  chk_end_bias: assert property (MEAS_STB && last && OPERATE |=> st_r == S_IDLE
                                 && src_r == $past(bias_r) && DONE)
    else $error("output not back at bias after last");
  // a full buffer always leaves the sequencer idle
  chk_buf_cap: assert property (cnt_r <= 10'(MAX_PTS)
                                && (cnt_r != 10'(MAX_PTS) || st_r == S_IDLE))
    else $error("buffer count beyond capacity");
endmodule // sws_top
`default_nettype wire

// ===== tb/sws_load_model.sv
`default_nettype none
// resistive load on the source output: reading tracks the applied level
module sws_load_model #(
  parameter logic [15:0] KEY = 16'h5A3C  // arbitrary load signature
) (
  input  wire logic        clk,
  input  wire logic        on,
  input  wire logic [15:0] lvl,
  output logic      [15:0] meas
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] junk_r = 16'h0000;  // churns while the output is off
  // no stale reading once output is off, so a late sample shows up
  always_ff @(posedge clk) junk_r <= {junk_r[14:0], ~junk_r[15]};
  // reading settles within the cycle the level is applied
  assign meas = on ? (lvl ^ KEY) : junk_r;
endmodule // sws_load_model
`default_nettype wire

// ===== tb/sws_top_tb_top.sv
`default_nettype none
module sws_top_tb_top import sws_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          T   = 3;         // shortened ms tick
  localparam logic [15:0] KEY = 16'h5A3C;  // load signature
  logic        clk = 1'b0, nrst = 1'b0, ce = 1'b1, oper = 1'b1;
  logic        trig = 1'b0, ptrig = 1'b0, pace = 1'b0, jit = 1'b0;
  logic [2:0]  wsel = 3'h0;
  logic [15:0] bias = 16'h0000, level = 16'h0000, start = 16'h0000;
  logic [15:0] stop = 16'h0000, step = 16'h0000, pts = 16'h0001;
  logic [15:0] dly = 16'h0000, ton = 16'h0001, toff = 16'h0001;
  logic [1:0]  ppd = 2'h0;
  logic [9:0]  raddr = 10'h000;
  logic [15:0] meas, src, rdat;
  logic [9:0]  bcnt;
  logic        stb, busy, done, filled;
  logic [31:0] seed = 32'hA7C5;           // xorshift state
  int          fails = 0, checks_done = 0, gap = 0, g;
  logic [15:0] lv_q[$];                   // expected level per strobe
  int          gp_q[$];                   // expected gap, <0 minimum, 0 free
  logic [15:0] all_q[$];                  // this sweep's levels for readback

  // 50 MHz clock
  initial forever #10 clk = ~clk;

  sws_top #(.TICK_CYC(T)) sws_top_inst (
    .CLK(clk), .NRST(nrst), .CE(ce), .OPERATE(oper), .TRIG(trig | ptrig),
    .TRIG_PACE(pace), .WAVE_SEL(wsel), .BIAS(bias), .LEVEL(level),
    .START_LVL(start), .STOP_LVL(stop), .STEP(step), .PPD_SEL(ppd),
    .POINTS(pts), .DELAY_MS(dly), .TON_MS(ton), .TOFF_MS(toff),
    .MEAS_DATA(meas), .RD_ADDR(raddr), .SRC_LEVEL(src), .MEAS_STB(stb),
    .BUSY(busy), .DONE(done), .BUF_FILLED(filled), .BUF_COUNT(bcnt),
    .RD_DATA(rdat));
  sws_load_model #(.KEY(KEY)) sws_load_model_inst (
    .clk(clk), .on(oper), .lvl(src), .meas(meas));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // next staircase level; log ratio truncated, at least one code up
  function automatic logic [15:0] nxt_lvl(input logic [15:0] l, input logic [2:0] w);
    logic [33:0] p;
    logic [17:0] r;
    logic [15:0] n;
    r = ppd == PPD_5 ? RATIO_PPD5 : ppd == PPD_10 ? RATIO_PPD10 :
        ppd == PPD_25 ? RATIO_PPD25 : RATIO_PPD50;
    p = {16'h0000, r} * {18'h00000, l};
    n = (p[31:16] > l) ? p[31:16] : l + 16'h0001;
    if (w == W_LIN || w == W_LPUL) n = l + step;
    if ($signed(stop) >= $signed(start) ? $signed(n) > $signed(stop)
                                        : $signed(n) < $signed(stop)) n = stop;
    return n;
  endfunction

  task automatic note(input logic [15:0] l, input int gp);
    lv_q.push_back(l);
    gp_q.push_back(gp);
    all_q.push_back(l);
  endtask

  // expected strobe sequence of one sweep
  task automatic plan(input logic [2:0] w);
    logic [15:0] l;
    int          n, i, t, f;
    bit          pul;
    pul = (w >= W_PULSE);
    n = (pts == 16'h0000) ? 1 : int'(pts);
    if (w == W_FIXED && n > 1000) n = 1000;
    if (w == W_PULSE && n > 500) n = 500;
    l = (w == W_FIXED || w == W_PULSE) ? level : start;
    t = (ton == 16'h0000) ? 1 : int'(ton);
    f = (toff == 16'h0000) ? 1 : int'(toff);
    all_q.delete();
    for (i = 0; i < 1000; i++) begin
      if (pul) note(l, (i == 0 || !pace) ? t * T + 1 : -13);
      else note(l, (i == 0 || !pace) ? int'(dly) * T + 1 : -13);
      // off reading at bias, after the full off time
      if (pul) note(bias, f * T + 1);
      if (w == W_FIXED || w == W_PULSE) begin
        if (i + 1 == n) break;
      end
      else if (l == stop) break;
      else l = nxt_lvl(l, w);
    end
  endtask

  // trigger held until an enabled edge
  task automatic fire();
    int k;
    trig = 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clk);
      if (ce) break;
    end
    @(negedge clk);
    trig = 1'b0;
    if (k == 64) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic wait_done();
    int k;
    for (k = 0; k < 9000; k++) begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    jit = 1'b0;
    if (k == 9000) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic sweep(input logic [2:0] w, input bit full);
    int i;
    wsel = w;
    plan(w);
    jit = !pace;
    fire();
    wait_done();
    @(negedge clk);
    check(src, bias);
    check(16'(lv_q.size()), 16'h0000);
    check(16'(bcnt), 16'(all_q.size()));
    check(16'(filled), 16'(full));
    // readback, then address 0x3FF reads zero
    for (i = 0; i <= all_q.size(); i++) begin
      raddr = (i == all_q.size()) ? 10'h3FF : 10'(i);
      @(negedge clk);
      check(rdat, (i == all_q.size()) ? 16'h0000 : all_q[i] ^ KEY);
    end
  endtask

  // scoreboard: each strobe takes the oldest note
  always @(posedge clk) begin
    if (busy !== 1'b1) gap = 0;
    else if (ce) gap++;
    if (stb === 1'b1) begin
      check(16'(lv_q.size() != 0), 16'h0001);
      if (lv_q.size() != 0) begin
        check(src, lv_q.pop_front());
        g = gp_q.pop_front();
        if (g > 0) check(16'(gap), 16'(g));
        if (g < 0) check(16'(gap >= -g), 16'h0001);
      end
      gap = 0;
    end
  end

  // random enable gaps; paced trigger after a pause
  always @(negedge clk) begin
    seed = xs(seed);
    ce <= !jit || seed[2:0] != 3'h0;
    ptrig <= pace && busy === 1'b1 && gap == 12;
  end

  initial begin
    int w, p;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    seed = xs(seed);
    bias = {6'h00, seed[9:0]};
    repeat (2) @(negedge clk);
    check(src, bias);
    // codes 6 and 7 start nothing
    for (w = 6; w < 8; w++) begin
      wsel = 3'(w);
      fire();
      repeat (2) @(negedge clk);
      check(16'(busy), 16'h0000);
    end
    seed = xs(seed);
    level = seed[15:0];
    start = 16'h0100;
    step = 16'h0040;
    stop = 16'h0210;
    pts = 16'h0003;
    dly = 16'h0002;
    ton = 16'h0000;
    toff = 16'h0002;
    // every shape; every points-per-decade code on the log staircase only
    for (w = 0; w < 6; w++) begin
      if (w == W_LPUL) begin
        start = 16'h0200;
        step = 16'hFF80;
        stop = 16'h0080;
      end
      if (w == W_LOG || w == W_GPUL) begin
        start = 16'h0064;
        stop = 16'h03E8;
      end
      for (p = 0; p < (w == W_LOG ? 4 : 1); p++) begin
        ppd = 2'(p);
        sweep(3'(w), 1'b0);
      end
    end
    pts = 16'h0000;
    sweep(W_FIXED, 1'b0);
    pts = 16'h03E9;
    dly = 16'h0000;
    sweep(W_FIXED, 1'b1);
    pace = 1'b1;
    start = 16'h0010;
    step = 16'h0008;
    stop = 16'h0020;
    sweep(W_LIN, 1'b0);
    // paced pulses step from the wait state
    sweep(W_LPUL, 1'b0);
    pace = 1'b0;
    // abort mid-sweep by dropping the output
    pts = 16'h0032;
    dly = 16'h0003;
    wsel = W_FIXED;
    plan(W_FIXED);
    fire();
    repeat (20) @(negedge clk);
    oper = 1'b0;
    wait_done();
    @(negedge clk);
    check(16'(busy), 16'h0000);
    lv_q.delete();
    gp_q.delete();
    oper = 1'b1;
    repeat (2) @(negedge clk);
    check(src, bias);
    complete_run();
  end
endmodule // sws_top_tb_top
`default_nettype wire
